// ---- core/cksr_regs.svh ----
// register map, field positions, reset values and thresholds of the colour killer block
`ifndef CKSR_REGS_SVH
`define CKSR_REGS_SVH
// ==========================================
// register offsets
`define CKSR_OFS_CTRL 8'h00
`define CKSR_OFS_STDEN 8'h04
`define CKSR_OFS_AMPK 8'h08
`define CKSR_OFS_ERRF 8'h0C
`define CKSR_OFS_STAT 8'h10
`define CKSR_OFS_NOTCH 8'h14
`define CKSR_OFS_LINES 8'h18
// ==========================================
// field positions
`define CKSR_CTRL_YC 0
`define CKSR_CTRL_COMB 1
`define CKSR_HYST_LSB 8
// ==========================================
// reset values
`define CKSR_RST_STDEN 7'h7F
`define CKSR_RST_THR 8'h20
`define CKSR_RST_HYST 8'h08
`define CKSR_RST_ERRF 4'h4
// ==========================================
// burst frequency windows in kHz
`define CKSR_F443_LO 16'h1144
`define CKSR_F443_HI 16'h1162
`define CKSR_FNTSC_LO 16'h0DFA
`define CKSR_FNTSC_HI 16'h0DFD
`define CKSR_FPALM_LO 16'h0DF5
`define CKSR_FPALM_HI 16'h0DF9
`define CKSR_FPALN_LO 16'h0DFE
`define CKSR_FPALN_HI 16'h0E01
`define CKSR_FSEC_LO 16'h1068
`define CKSR_FSEC_HI 16'h1143
`define CKSR_FSEC_STEP 16'h0064
// ==========================================
// lines per field windows
`define CKSR_L625_LO 10'h120
`define CKSR_L625_HI 10'h140
`define CKSR_L525_LO 10'h0F0
`define CKSR_L525_HI 10'h11F
`endif

// ---- core/cksr_pkg.sv ----
// types shared by the colour killer and standard recognition block
package cksr_pkg;
  // ==========================================
  // recognised standards, order gives the enable bit index
  typedef enum logic [2:0] {
    STD_PAL, STD_NTSC_M, STD_SECAM, STD_NTSC44, STD_PAL_M, STD_PAL_N, STD_PAL60, STD_NONE
  } cksr_std_t;
  typedef enum logic [1:0] {S_IDLE, S_ARM, S_MEAS} cksr_srch_t;
  // video samples from the front end, signed
  typedef struct packed {
    logic active;
    logic line_start;
    logic field_start;
    logic signed [9:0] luma;
    logic signed [9:0] chroma;
  } cksr_video_t;
  // per-line burst measurement
  typedef struct packed {
    logic valid;
    logic [15:0] freq;
    logic [7:0] amp;
    logic pll_lock;
    logic alt;
  } cksr_burst_t;
  // processed pixel out
  typedef struct packed {
    logic valid;
    logic signed [9:0] luma;
    logic signed [9:0] chroma;
    logic signed [9:0] chroma_alt;
  } cksr_pix_t;
  // recognition status indications
  typedef struct packed {
    logic busy;
    logic failed;
    logic disabled;
    logic vinvalid;
    logic nocolor;
  } cksr_rstat_t;
endpackage

// ---- core/cksr_top.sv ----
// colour killer, standard recognition, single line delay and luma notch control
//
// Contract
// - PAL/NTSC colour off while the subcarrier loop is unlocked.
// - SECAM colour kill follows line-to-line burst frequency toggling.
// - colour off while burst amplitude is below the programmed threshold.
// - amplitude kill restores only above threshold plus programmed hysteresis; the code also restores at exactly that sum.
// - recognition uses burst frequency plus horizontal and vertical lock.
// - seven standard classes distinguished, PAL B/G/H/I as one.
// - host enables each standard; only enabled ones are accepted.
// - with any standard enabled, check locks and killer every field.
// - error over programmed consecutive fields starts a new search.
// - search picks standard from lines per field and burst frequency.
// - status: busy, failed, disabled standard, vertical invalid, no colour.
// - one line delay, written with active-video samples only.
// - delay: NTSC comb or compensation, PAL compensation, SECAM crossover.
// - NTSC compensated chroma is average of current and delayed line.
// - NTSC comb puts the delay in the composite path before separation.
// - NTSC comb adds back chroma-free vertical detail to luma.
// - PAL/NTSC notch centre tracks measured subcarrier frequency.
// - SECAM notch centre set from measured chroma carrier.
// - separate luma/chroma input bypasses the notch.
// - SECAM burst frequency measured per line and drives the killer.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "cksr_regs.svh"

module cksr_top import cksr_pkg::*; #(
  parameter int DEPTH = 1080,
  parameter int AW = 11
) (
  input wire logic clock, // 25 MHz
  input wire logic srst, // sync reset, high
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input cksr_video_t vin, // video samples
  input cksr_burst_t bin, // burst measurement
  input wire logic h_lock, // horizontal lock
  input wire logic v_lock, // vertical lock
  output cksr_pix_t pout, // decoded pixel
  output logic [15:0] notch_freq, // notch centre, kHz
  output logic notch_bypass, // notch bypassed
  output logic color_on, // colour not killed
  output cksr_std_t std_cur, // standard in use
  output cksr_rstat_t rstat // recognition status
);

  // ==========================================
  // state
  typedef struct packed {
    logic yc;
    logic comb;
    logic [6:0] std_en;
    logic [7:0] thr;
    logic [7:0] hyst;
    logic [3:0] errf;
    logic [31:0] rdata;
    logic amp_kill;
    logic sec_tog;
    logic [15:0] last_freq;
    logic [15:0] nf;
    logic [9:0] line_cnt;
    logic [9:0] lines_last;
    logic [3:0] err_cnt;
    cksr_srch_t srch;
    cksr_std_t std;
    cksr_rstat_t st;
    logic f443;
    logic fntsc;
    logic fpalm;
    logic fpaln;
    logic fsec;
    logic falt;
    logic [AW-1:0] wptr;
    logic parity;
    logic pv;
    logic signed [9:0] cy;
    logic signed [9:0] cc;
    logic signed [9:0] hd1;
    logic signed [9:0] hd2;
    cksr_pix_t pix;
  } cksr_state_t;

  cksr_state_t r;
  cksr_state_t next_r;

  logic signed [9:0] mem [DEPTH];
  logic signed [9:0] dly;
  logic signed [9:0] wsample;
  logic comb_mode;
  logic killed;

  // 10-bit saturation of an 11-bit signed value
  function automatic logic signed [9:0] cksr_sat(input logic signed [10:0] v);
    logic signed [9:0] o;
    o = v[9:0];
    if (v[10] != v[9]) begin
      o = v[10] ? 10'sh200 : 10'sh1FF;
    end
    return o;
  endfunction

  function automatic logic in_win(input logic [15:0] f, input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (f >= lo) && (f <= hi);
  endfunction

  // ==========================================
  // mode decode and killer
  always_comb begin
    comb_mode = r.comb && !r.yc && (r.std == STD_NTSC_M || r.std == STD_NTSC44);
    killed = r.amp_kill;
    // no adopted standard keeps the colour off
    case (r.std)
      STD_SECAM: killed = r.amp_kill || !r.sec_tog;
      STD_NONE: killed = 1'b1;
      default: killed = r.amp_kill || !bin.pll_lock;
    endcase
    // composite into delay in comb mode, chroma otherwise
    wsample = comb_mode ? vin.luma : vin.chroma;
  end

  // ==========================================
  // line delay, active samples only
  // blanking samples never enter, so the pointer indexes the active sample
  always_ff @(posedge clock) begin
    if (vin.active) begin
      mem[r.wptr] <= wsample;
      dly <= mem[r.wptr];
    end
  end

  // ==========================================
  // next state
  always_comb begin
    logic [15:0] fdiff;
    logic [8:0] restore;
    logic v625;
    logic v525;
    logic fld_err;
    cksr_std_t cand;
    logic signed [10:0] sum;
    logic signed [10:0] dif;
    logic signed [10:0] vdet;
    logic signed [9:0] avg;
    logic signed [9:0] hdif;
    fdiff = 16'h0000;
    restore = 9'h000;
    v625 = 1'b0;
    v525 = 1'b0;
    fld_err = 1'b0;
    cand = STD_NONE;
    sum = 11'sh000;
    dif = 11'sh000;
    vdet = 11'sh000;
    avg = 10'sh000;
    hdif = 10'sh000;
    next_r = r;
    next_r.rdata = 32'h0000_0000;

    // register writes
    if (wr) begin
      case (addr)
        `CKSR_OFS_CTRL: begin
          next_r.yc = wdata[`CKSR_CTRL_YC];
          next_r.comb = wdata[`CKSR_CTRL_COMB];
        end
        `CKSR_OFS_STDEN: next_r.std_en = wdata[6:0];
        `CKSR_OFS_AMPK: begin
          next_r.thr = wdata[7:0];
          next_r.hyst = wdata[`CKSR_HYST_LSB +: 8];
        end
        `CKSR_OFS_ERRF: next_r.errf = wdata[3:0];
        default: ;
      endcase
    end
    // register reads
    if (rd) begin
      case (addr)
        `CKSR_OFS_CTRL: next_r.rdata = {30'h0000_0000, r.comb, r.yc};
        `CKSR_OFS_STDEN: next_r.rdata = {25'h000_0000, r.std_en};
        `CKSR_OFS_AMPK: next_r.rdata = {16'h0000, r.hyst, r.thr};
        `CKSR_OFS_ERRF: next_r.rdata = {28'h000_0000, r.errf};
        `CKSR_OFS_STAT: next_r.rdata = {23'h00_0000, !killed, r.st, 3'(r.std)};
        `CKSR_OFS_NOTCH: next_r.rdata = {15'h0000, !r.yc, r.yc ? 16'h0000 : r.nf};
        `CKSR_OFS_LINES: next_r.rdata = {22'h00_0000, r.lines_last};
        default: next_r.rdata = 32'h0000_0000;
      endcase
    end

    // burst measurements, one per line
    if (bin.valid) begin
      // kill below threshold, restore only at or above threshold plus hysteresis
      restore = {1'b0, r.thr} + {1'b0, r.hyst};
      if (bin.amp < r.thr) begin
        next_r.amp_kill = 1'b1;
      end else if ({1'b0, bin.amp} >= restore) begin
        next_r.amp_kill = 1'b0;
      end
      // secam carrier must step by a full line-to-line swing
      fdiff = (bin.freq > r.last_freq) ? bin.freq - r.last_freq : r.last_freq - bin.freq;
      next_r.sec_tog = (fdiff >= `CKSR_FSEC_STEP) &&
                       in_win(bin.freq, `CKSR_FSEC_LO, `CKSR_FSEC_HI);
      next_r.last_freq = bin.freq;
      // notch follows the locked subcarrier, or the secam carrier as measured
      if (r.std == STD_SECAM || bin.pll_lock) begin
        next_r.nf = bin.freq;
      end
      // frequency classes seen during the measured field
      if (r.srch == S_MEAS) begin
        next_r.f443 = r.f443 || in_win(bin.freq, `CKSR_F443_LO, `CKSR_F443_HI);
        next_r.fntsc = r.fntsc || in_win(bin.freq, `CKSR_FNTSC_LO, `CKSR_FNTSC_HI);
        next_r.fpalm = r.fpalm || in_win(bin.freq, `CKSR_FPALM_LO, `CKSR_FPALM_HI);
        next_r.fpaln = r.fpaln || in_win(bin.freq, `CKSR_FPALN_LO, `CKSR_FPALN_HI);
        next_r.fsec = r.fsec || next_r.sec_tog;
        next_r.falt = r.falt || bin.alt;
      end
    end

    // lines per field
    if (vin.line_start) begin
      next_r.line_cnt = r.line_cnt + 10'h001;
      next_r.parity = !r.parity;
      next_r.wptr = '0;
    end else if (vin.active) begin
      next_r.wptr = r.wptr + AW'(1);
    end
    // the line that carries the field start is the first of the new field
    if (vin.field_start) begin
      next_r.line_cnt = 10'h001;
      next_r.lines_last = r.line_cnt;
    end

    // candidate from lines and burst frequency
    v625 = (r.line_cnt >= `CKSR_L625_LO) && (r.line_cnt <= `CKSR_L625_HI);
    v525 = (r.line_cnt >= `CKSR_L525_LO) && (r.line_cnt <= `CKSR_L525_HI);
    if (v625) begin
      if (r.fsec) cand = STD_SECAM;
      else if (r.f443) cand = STD_PAL;
      else if (r.fpaln) cand = STD_PAL_N;
    end else if (v525) begin
      if (r.f443) cand = r.falt ? STD_PAL60 : STD_NTSC44;
      else if (r.fpalm) cand = STD_PAL_M;
      else if (r.fntsc) cand = STD_NTSC_M;
    end

    // field monitor and search sequence
    if (vin.field_start) begin
      case (r.srch)
        S_IDLE: begin
          // a lost lock or a killed colour marks the field as bad
          fld_err = !h_lock || !v_lock || killed;
          if (r.std_en == 7'h00) begin
            next_r.err_cnt = 4'h0;
          end else if (fld_err) begin
            next_r.err_cnt = r.err_cnt + 4'h1;
            if (r.err_cnt + 4'h1 >= r.errf) begin
              next_r.err_cnt = 4'h0;
              next_r.srch = S_ARM;
              next_r.st = '0;
              next_r.st.busy = 1'b1;
            end
          end else begin
            next_r.err_cnt = 4'h0;
          end
        end
        S_ARM: begin
          // flags start clean so only the measured field counts
          next_r.srch = S_MEAS;
          next_r.f443 = 1'b0;
          next_r.fntsc = 1'b0;
          next_r.fpalm = 1'b0;
          next_r.fpaln = 1'b0;
          next_r.fsec = 1'b0;
          next_r.falt = 1'b0;
        end
        S_MEAS: begin
          // outcome flags stand until the next search clears them
          next_r.srch = S_IDLE;
          next_r.st.busy = 1'b0;
          if (!v625 && !v525) begin
            next_r.st.vinvalid = 1'b1;
            next_r.st.failed = 1'b1;
          end else if (cand == STD_NONE) begin
            next_r.st.nocolor = 1'b1;
            next_r.st.failed = 1'b1;
          end else if (!r.std_en[3'(cand)]) begin
            next_r.st.disabled = 1'b1;
            next_r.st.failed = 1'b1;
          end else begin
            next_r.std = cand;
          end
        end
        default: next_r.srch = S_IDLE;
      endcase
    end

    // pixel path, delayed sample meets current one
    next_r.pv = vin.active;
    next_r.cy = vin.luma;
    next_r.cc = comb_mode ? vin.luma : vin.chroma;
    // half sum and half difference of the line pair
    sum = 11'(r.cc) + 11'(dly);
    dif = 11'(r.cc) - 11'(dly);
    avg = sum[10:1];
    hdif = dif[10:1];
    // detail history advances only on valid samples
    if (r.pv) begin
      next_r.hd1 = hdif;
      next_r.hd2 = r.hd1;
    end
    // two samples apart cancels the subcarrier in the detail
    vdet = (11'(hdif) + 11'(r.hd2)) >>> 1;
    next_r.pix.valid = r.pv;
    next_r.pix.luma = r.cy;
    next_r.pix.chroma = r.cc;
    next_r.pix.chroma_alt = 10'sh000;
    // the single delay serves a different purpose per standard
    case (r.std)
      STD_NTSC_M, STD_NTSC44: begin
        if (comb_mode) begin
          next_r.pix.luma = cksr_sat(11'(avg) + vdet);
          next_r.pix.chroma = hdif;
        end else begin
          next_r.pix.chroma = avg;
        end
      end
      STD_PAL, STD_PAL_M, STD_PAL_N, STD_PAL60: next_r.pix.chroma = avg;
      STD_SECAM: begin
        next_r.pix.chroma = r.parity ? dly : r.cc;
        next_r.pix.chroma_alt = r.parity ? r.cc : dly;
      end
      default: ;
    endcase
    // a killed colour blanks both chroma channels
    if (killed) begin
      next_r.pix.chroma = 10'sh000;
      next_r.pix.chroma_alt = 10'sh000;
    end
  end

  // ==========================================
  // register update
  always_ff @(posedge clock) begin
    if (srst) begin
      // sample memory is not cleared, its first line reads as unknown
      r <= '0;
      r.std_en <= `CKSR_RST_STDEN;
      r.thr <= `CKSR_RST_THR;
      r.hyst <= `CKSR_RST_HYST;
      r.errf <= `CKSR_RST_ERRF;
      r.amp_kill <= 1'b1;
      r.srch <= S_IDLE;
      r.std <= STD_NONE;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================
  // outputs
  assign rdata = r.rdata;
  assign pout = r.pix;
  assign notch_freq = r.yc ? 16'h0000 : r.nf;
  assign notch_bypass = r.yc;
  assign color_on = !killed;
  assign std_cur = r.std;
  assign rstat = r.st;

endmodule

// ---- bench/cksr_top_asserts.sv ----
// port checker for the colour killer and standard recognition block
`timescale 1ns/1ps
`include "cksr_regs.svh"
module cksr_top_asserts import cksr_pkg::*; #(
  parameter int DEPTH = 1080,
  parameter int AW = 11
) (
  input wire logic clock, // clock
  input wire logic srst, // reset
  input wire logic [7:0] addr, // address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write
  input wire logic rd, // read
  input wire logic [31:0] rdata, // read data
  input cksr_video_t vin, // video
  input cksr_burst_t bin, // burst
  input wire logic h_lock, // h lock
  input wire logic v_lock, // v lock
  input cksr_pix_t pout, // pixel
  input wire logic [15:0] notch_freq, // notch
  input wire logic notch_bypass, // bypass
  input wire logic color_on, // colour
  input cksr_std_t std_cur, // standard
  input cksr_rstat_t rstat // status
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic [7:0] thr;
  logic [7:0] hyst;
  logic [6:0] en;
  logic amp_k;
  // ==========================================
  // shadow of threshold, enables and amplitude kill state
  always_ff @(posedge clock) begin
    if (srst) begin
      thr <= `CKSR_RST_THR;
      hyst <= `CKSR_RST_HYST;
      en <= `CKSR_RST_STDEN;
      amp_k <= 1'b1;
    end else begin
      if (wr && addr == `CKSR_OFS_AMPK) begin
        thr <= wdata[7:0];
        hyst <= wdata[15:8];
      end
      if (wr && addr == `CKSR_OFS_STDEN) begin
        en <= wdata[6:0];
      end
      if (bin.valid && bin.amp < thr) begin
        amp_k <= 1'b1;
      end else if (bin.valid && {1'b0, bin.amp} >= {1'b0, thr} + {1'b0, hyst}) begin
        amp_k <= 1'b0;
      end
    end
  end
  // ==========================================
  // assertions
  a_pll_kill: assert property (!bin.pll_lock && std_cur != STD_SECAM
    && std_cur != STD_NONE |-> !color_on) else $error("colour on while loop unlocked");
  a_amp_kill: assert property (amp_k |-> !color_on)
    else $error("colour on while amplitude killed");
  a_srch_field: assert property ($rose(rstat.busy) |-> $past(vin.field_start))
    else $error("search began off a field start");
  a_srch_clear: assert property ($rose(rstat.busy) |-> rstat[3:0] == 4'h0)
    else $error("status not cleared at search start");
  a_srch_idle: assert property (en == 7'h00 && !rstat.busy |=> !rstat.busy)
    else $error("search with no standard enabled");
  a_std_enabled: assert property ($fell(rstat.busy) && !rstat.failed
    |-> std_cur != STD_NONE && en[std_cur]) else $error("adopted standard not enabled");
  a_stat_hold: assert property ($stable(rstat.busy)
    |-> $stable(rstat) && $stable(std_cur)) else $error("status moved outside search edges");
  a_pix_valid: assert property (pout.valid == $past(vin.active, 2))
    else $error("pixel valid not two cycles after active sample");
  a_bypass_zero: assert property (notch_bypass |-> notch_freq == 16'h0000)
    else $error("notch frequency while bypassed");
  a_stat_read: assert property (rd && addr == `CKSR_OFS_STAT |=>
    rdata[8:0] == {$past(color_on), $past(rstat), $past(std_cur)})
    else $error("status read mismatch");
  a_rdata_idle: assert property (!rd |=> rdata == 32'h00000000)
    else $error("read data outside read cycle");
endmodule
bind cksr_top cksr_top_asserts #(.DEPTH(DEPTH), .AW(AW)) i_chk (.clock(clock), .srst(srst),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vin(vin), .bin(bin),
  .h_lock(h_lock), .v_lock(v_lock), .pout(pout), .notch_freq(notch_freq),
  .notch_bypass(notch_bypass), .color_on(color_on), .std_cur(std_cur), .rstat(rstat));

// ---- bench/cksr_vsrc.sv ----
// video source standing in for the front-end converters
`timescale 1ns/1ps
module cksr_vsrc import cksr_pkg::*; (
  input wire logic clock, // clock
  input wire logic srst, // reset
  input wire logic [9:0] lines, // lines per field
  input wire logic [15:0] freq, // burst frequency, kHz
  input wire logic [7:0] amp, // burst amplitude
  input wire logic lock, // subcarrier loop locked
  input wire logic alt, // phase alternation seen
  input wire logic signed [9:0] chroma, // chroma level
  output cksr_video_t vin, // video samples
  output cksr_burst_t bin // burst measurement
);
  logic [3:0] pos;
  logic [9:0] ln;
  logic [9:0] pat;
  // sixteen-cycle lines, field wraps at the line count
  always_ff @(posedge clock) begin
    if (srst) begin
      pos <= 4'h0;
      ln <= 10'h000;
      pat <= 10'h000;
    end else begin
      pos <= pos + 4'h1;
      pat <= pat + 10'h025;
      if (pos == 4'hF) begin
        ln <= (ln + 10'h001 >= lines) ? 10'h000 : ln + 10'h001;
      end
    end
  end
  // inactive samples and cycles without a burst carry the inverse so stale data never looks valid
  always_comb begin
    vin.line_start = (pos == 4'h0);
    vin.field_start = (pos == 4'h0) && (ln == 10'h000);
    vin.active = (pos >= 4'h4) && (pos < 4'hA);
    vin.luma = vin.active ? $signed(pat) : $signed(~pat);
    vin.chroma = vin.active ? chroma : ~chroma;
    bin.valid = (pos == 4'h2);
    bin.freq = bin.valid ? freq : ~freq;
    bin.amp = bin.valid ? amp : ~amp;
    bin.pll_lock = lock;
    bin.alt = alt;
  end
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the colour killer block
`timescale 1ns/1ps
`include "cksr_regs.svh"
module tb;
  import cksr_pkg::*;
  logic clock;
  logic srst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic h_lock = 1'b1, v_lock = 1'b1, lock = 1'b1, alt = 1'b1;
  logic [9:0] lines = 10'h12C;
  logic [15:0] freq = 16'h1151;
  logic [7:0] amp = 8'h60;
  logic signed [9:0] chroma = 10'h064;
  cksr_video_t vin;
  cksr_burst_t bin;
  cksr_pix_t pout;
  logic [15:0] notch_freq;
  logic notch_bypass, color_on;
  cksr_std_t std_cur;
  cksr_rstat_t rstat;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] rs = 32'h00008546;
  logic [7:0] offs [3] = '{`CKSR_OFS_STDEN, `CKSR_OFS_AMPK, `CKSR_OFS_ERRF};
  logic [31:0] msk [3] = '{32'h0000007F, 32'h0000FFFF, 32'h0000000F};
  logic [7:0] corner [5] = '{8'h1F, 8'h27, 8'h28, 8'h27, 8'h1F};
  cksr_vsrc i_src (.clock(clock), .srst(srst), .lines(lines), .freq(freq), .amp(amp),
    .lock(lock), .alt(alt), .chroma(chroma), .vin(vin), .bin(bin));
  cksr_top #(.DEPTH(1080), .AW(11)) i_dut (.clock(clock), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .vin(vin), .bin(bin), .h_lock(h_lock),
    .v_lock(v_lock), .pout(pout), .notch_freq(notch_freq), .notch_bypass(notch_bypass),
    .color_on(color_on), .std_cur(std_cur), .rstat(rstat));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // expected amplitude kill state after one burst
  function automatic logic kill_next(input logic k, input logic [7:0] a);
    if (a < `CKSR_RST_THR) return 1'b1;
    if ({1'b0, a} >= {1'b0, `CKSR_RST_THR} + {1'b0, `CKSR_RST_HYST}) return 1'b0;
    return k;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    @(negedge clock);
    check(rdata, exp);
  endtask
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (rstat.busy !== v && n < 30000) begin
      @(negedge clock);
      n++;
    end
    check(rstat.busy, v);
  endtask
  // feed the new standard and drop one lock in the same cycle until a search starts
  task automatic search(input logic [9:0] l, input logic [15:0] f, input logic hl);
    @(posedge clock);
    lines <= l;
    freq <= f;
    if (hl) h_lock <= 1'b0;
    else v_lock <= 1'b0;
    wait_busy(1'b1);
    @(posedge clock);
    h_lock <= 1'b1;
    v_lock <= 1'b1;
    wait_busy(1'b0);
  endtask
  task automatic chroma_line(input logic signed [9:0] c);
    repeat (16) begin
      @(negedge clock);
      if (pout.valid === 1'b1) begin
        check(pout.chroma, c);
        check(pout.chroma_alt, 10'h000);
      end
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ==========================================
  // clock and watchdog
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    repeat (80000) @(posedge clock);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
  // ==========================================
  // main sequence
  initial begin
    logic [31:0] d;
    logic k;
    repeat (10) @(posedge clock);
    srst <= 1'b0;
    rd_chk(`CKSR_OFS_CTRL, 32'h00000000);
    rd_chk(`CKSR_OFS_STDEN, 32'h0000007F);
    rd_chk(`CKSR_OFS_AMPK, 32'h00000820);
    rd_chk(`CKSR_OFS_ERRF, 32'h00000004);
    rd_chk(`CKSR_OFS_STAT, 32'h00000007);
    for (int i = 0; i < 12; i++) begin
      d = xs();
      wr_reg(offs[i % 3], d);
      rd_chk(offs[i % 3], d & msk[i % 3]);
    end
    wr_reg(`CKSR_OFS_STAT, 32'hFFFFFFFF);
    wr_reg(8'h1C, 32'hFFFFFFFF);
    rd_chk(8'h1C, 32'h00000000);
    rd_chk(`CKSR_OFS_STAT, 32'h00000007);
    wr_reg(`CKSR_OFS_STDEN, 32'h0000007F);
    wr_reg(`CKSR_OFS_AMPK, 32'h00000820);
    wr_reg(`CKSR_OFS_ERRF, 32'h00000001);
    // unknown standard at start: search finds 625 lines at 4.43 MHz
    wait_busy(1'b1);
    wait_busy(1'b0);
    check(std_cur, STD_PAL);
    check(rstat, 5'h00);
    check(color_on, 1'b1);
    repeat (40) @(negedge clock);
    check(notch_freq, freq);
    rd_chk(`CKSR_OFS_NOTCH, {15'h0000, 1'b1, freq});
    wr_reg(`CKSR_OFS_CTRL, 32'h00000001);
    repeat (4) @(negedge clock);
    check(notch_bypass, 1'b1);
    rd_chk(`CKSR_OFS_NOTCH, 32'h00000000);
    wr_reg(`CKSR_OFS_CTRL, 32'h00000000);
    // amplitude around threshold and hysteresis, corners then random
    wr_reg(`CKSR_OFS_ERRF, 32'h0000000F);
    k = 1'b0;
    for (int i = 0; i < 10; i++) begin
      d = xs();
      if (i < 5) d = {24'h000000, corner[i]};
      @(posedge clock);
      amp <= d[7:0];
      k = kill_next(k, d[7:0]);
      repeat (20) @(negedge clock);
      check(color_on, !k);
    end
    @(posedge clock);
    amp <= 8'h60;
    lock <= 1'b0;
    repeat (20) @(negedge clock);
    check(color_on, 1'b0);
    chroma_line(10'h000);
    @(posedge clock);
    lock <= 1'b1;
    // 525 lines at 3.58 MHz with that standard disabled, then enabled
    wr_reg(`CKSR_OFS_STDEN, 32'h0000007D);
    wr_reg(`CKSR_OFS_ERRF, 32'h00000001);
    search(10'h106, 16'h0DFB, 1'b1);
    check(rstat, 5'h0C);
    wr_reg(`CKSR_OFS_STDEN, 32'h0000007F);
    search(10'h106, 16'h0DFB, 1'b0);
    check(std_cur, STD_NTSC_M);
    check(rstat, 5'h00);
    rd_chk(`CKSR_OFS_LINES, 32'h00000106);
    repeat (40) @(negedge clock);
    chroma_line(chroma);
    // 525 lines at 4.43 MHz without phase alternation
    @(posedge clock);
    alt <= 1'b0;
    search(10'h106, 16'h1151, 1'b0);
    check(std_cur, STD_NTSC44);
    check(rstat, 5'h00);
    wrap_up();
  end
endmodule
